// *** startup_timing_params.svh ***
// Offsets, field positions, reset values and timing constants of the start-up sequencer
`ifndef STARTUP_TIMING_PARAMS_SVH
`define STARTUP_TIMING_PARAMS_SVH

// Command codes of the three timing words
`define CMD_TURN_ON_DELAY 8'h60
`define CMD_SOFT_START_RAMP_TIME 8'h61
`define CMD_START_TIME_FAULT_LIMIT 8'h62

// Linear word layout: exponent 15:11, mantissa 10:0
`define EXP_MSB 15
`define EXP_LSB 11
`define MAN_MSB 10
`define MAN_LSB 0

// Exponent reset values; mantissas come from nonvolatile memory
`define DELAY_EXP_RST 5'h1f
`define RAMP_EXP_RST 5'h1e
`define LIMIT_EXP_RST 5'h1f

// Supported ranges in quarter milliseconds; HALF_MS_MAX in half milliseconds
`define DELAY_MAX_Q 12'h1fe
`define RAMP_MAX_Q 12'h07f
`define LIMIT_MAX_Q 12'h1fc
`define RAMP_MIN_Q 12'h002
`define HALF_MS_MAX 12'h0ff

// Start-time fault action codes
`define ACT_IGNORE 2'h0
`define ACT_DELAYED 2'h1
`define ACT_IMMEDIATE 2'h2

// Timing
`define CLK_PERIOD_NS 10
`define QUARTER_MS_NS 250000
`define MIN_START_DELAY_NS 100000
`define QUARTER_CYCLES (`QUARTER_MS_NS / `CLK_PERIOD_NS)
`define MIN_START_CYCLES ((`MIN_START_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** startup_timing_pkg.sv ***
// Types shared by the start-up sequencer files
package startup_timing_pkg;

    // One timing word in linear format
    typedef struct packed {
        logic [4:0] exponent;
        logic [10:0] mantissa;
    } linear_word_type;

    // Command port request: word write or read
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic [15:0] data;
    } cmd_req_type;

    // Start sequence states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_DELAY = 5'h02,
        ST_RAMP = 5'h04,
        ST_ON = 5'h08,
        ST_OFF = 5'h10
    } seq_state_type;

endpackage

// *** linear_to_quarters.sv ***
// Converts a linear-format millisecond word into quarter milliseconds
`timescale 1ns/100ps
`default_nettype none
module linear_to_quarters
    import startup_timing_pkg::*;
(
    input wire linear_word_type i_word,
    output logic [11:0] o_quarters,
    output logic o_exact,
    output logic o_negative
);
    logic signed [6:0] shift; // Exponent plus two: quarter units
    logic [4:0] rshift;
    logic [26:0] mag;
    logic [26:0] wide;

    // Mantissa times two to the exponent, rounded to the nearest quarter
    always_comb begin
        shift = $signed({{2{i_word.exponent[4]}}, i_word.exponent}) + 7'sd2;
        mag = {17'h00000, i_word.mantissa[9:0]};
        o_negative = i_word.mantissa[10];
        rshift = 5'h00;
        o_exact = 1'b1;
        if (!shift[6]) begin
            wide = mag << shift[4:0];
        end else begin
            // Negative shift drops bits; the last dropped bit rounds
            rshift = 5'(-shift);
            wide = mag >> rshift;
            o_exact = (mag & ((27'h1 << rshift) - 27'h1)) == 27'h0;
            if (mag[rshift - 5'h1]) begin
                wide = wide + 27'h1;
            end
        end
        // Saturate: anything this large is out of range for every word
        o_quarters = (|wide[26:12]) ? 12'hfff : wide[11:0];
    end
endmodule
`default_nettype wire

// *** quarter_timer.sv ***
// Quarter-millisecond down-counter with tick and done pulses
`timescale 1ns/100ps
`default_nettype none
module quarter_timer #(
    parameter int TICK_CYCLES = 25000
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [11:0] i_quarters,
    output logic o_tick,
    output logic o_done,
    output logic o_busy
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    logic busy_r, busy_nxt, tick_r, tick_nxt, done_r, done_nxt;
    logic [11:0] left_r, left_nxt; // Quarters still to run
    logic [CW-1:0] cyc_r, cyc_nxt; // Cycles inside current quarter

    // Start wins over stop; zero quarters finish at once
    always_comb begin
        busy_nxt = busy_r;
        left_nxt = left_r;
        cyc_nxt = cyc_r;
        tick_nxt = 1'b0;
        done_nxt = 1'b0;
        if (i_start) begin
            busy_nxt = i_quarters != 12'h000;
            done_nxt = i_quarters == 12'h000;
            left_nxt = i_quarters;
            cyc_nxt = '0;
        end else if (i_stop) begin
            busy_nxt = 1'b0;
        end else if (busy_r) begin
            if (cyc_r == CW'(TICK_CYCLES - 1)) begin
                cyc_nxt = '0;
                tick_nxt = 1'b1;
                left_nxt = left_r - 12'h001;
                if (left_r == 12'h001) begin
                    busy_nxt = 1'b0;
                    done_nxt = 1'b1;
                end
            end else begin
                cyc_nxt = cyc_r + CW'(1);
            end
        end
    end

    // Registers only; clock enable freezes everything
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_r <= 1'b0;
            left_r <= 12'h000;
            cyc_r <= '0;
            tick_r <= 1'b0;
            done_r <= 1'b0;
        end else if (i_ce) begin
            busy_r <= busy_nxt;
            left_r <= left_nxt;
            cyc_r <= cyc_nxt;
            tick_r <= tick_nxt;
            done_r <= done_nxt;
        end
    end

    assign o_tick = tick_r;
    assign o_done = done_r;
    assign o_busy = busy_r;
endmodule
`default_nettype wire

// *** startup_timing_sequencer.sv ***
// Start-up delay, soft-start ramp and start-time fault sequencer
// What this block does
// R1 - wait turn-on delay after selected start
// R2 - exponent 15:11, mantissa 10:0, reset exponents
// R3 - at least about 100 us start delay
// R4 - out-of-range write flagged, host notified
// R5 - delay 0 to 127.5 ms, 0.5 ms
// R6 - restored delay rounded to supported value
// R7 - ramp reaches regulation in programmed time
// R8 - slope derived from target voltage
// R9 - slope quantised; duration still programmed
// R10 - ramp 0 to 31.75 ms, 0.25 ms
// R11 - ramp below 0.5 ms runs 0.5 ms
// R12 - limit timer starts at delay end
// R13 - expiry compares sample with 87.5 percent
// R14 - last sample may lag expiry
// R15 - limit 0 to 127 ms, 0.5 ms
// R16 - zero limit disables fault detection
// R17 - undervoltage armed at ramp end
// R18 - fault action: ignore, delayed, immediate
// R19 - value is mantissa times two^exponent ms
`include "startup_timing_params.svh"
`timescale 1ns/100ps
`default_nettype none
module startup_timing_sequencer
    import startup_timing_pkg::*;
#(
    parameter int QUARTER_CYCLES = `QUARTER_CYCLES,
    parameter int MIN_START_CYCLES = `MIN_START_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire cmd_req_type i_req,
    input wire linear_word_type [2:0] i_nvm_words,
    input wire logic i_restore,
    input wire logic i_clear_faults,
    input wire logic [1:0] i_start_source,
    input wire logic i_operation_on,
    input wire logic i_control_pin,
    input wire logic [15:0] i_target_voltage,
    input wire logic [15:0] i_telemetry,
    input wire logic i_telemetry_valid,
    input wire logic [1:0] i_fault_action,
    input wire logic [2:0] i_fault_delay_ms,
    output logic [15:0] o_rd_data,
    output logic [15:0] o_ref_code,
    output logic o_uv_armed,
    output logic o_shutdown,
    output logic o_start_fault,
    output logic o_invalid_data,
    output logic o_alert
);
    localparam int MW = $clog2(MIN_START_CYCLES + 1);

    linear_word_type word_r [3], word_nxt [3]; // Timing words, index = cmd - 0x60
    logic [11:0] q_r [3], q_nxt [3]; // Same words in quarter ms
    logic [15:0] rd_r, rd_nxt;
    logic inv_r, inv_nxt; // Invalid-data status
    logic loading_r, loading_nxt; // Nonvolatile load in progress
    logic [1:0] idx_r, idx_nxt;
    linear_word_type conv_in;
    logic [11:0] conv_q, hq;
    logic conv_exact, conv_neg, hit;
    logic [1:0] sel;

    // Top supported value per word
    function automatic logic [11:0] max_q(input logic [1:0] i);
        max_q = (i == 2'h0) ? `DELAY_MAX_Q : (i == 2'h1) ? `RAMP_MAX_Q : `LIMIT_MAX_Q;
    endfunction

    // Steps of one quarter for the ramp, one half for the others
    function automatic logic wr_ok(input logic [1:0] i, input logic [11:0] q,
                                   input logic ex, input logic ng);
        wr_ok = !ng && ex && (q <= max_q(i)) && !(i != 2'h1 && q[0]);
    endfunction

    // Ceiling log2, used to pick a power-of-two ramp slope
    function automatic logic [3:0] clog(input logic [11:0] v);
        clog = 4'h0;
        for (int k = 0; k < 12; k++) begin
            if ((12'h001 << k) < v) begin
                clog = 4'(k + 1);
            end
        end
    endfunction

    // One converter serves both the loader and the write path
    linear_to_quarters conv (
        .i_word(conv_in),
        .o_quarters(conv_q),
        .o_exact(conv_exact),
        .o_negative(conv_neg)
    );

    assign sel = 2'(i_req.cmd - `CMD_TURN_ON_DELAY);
    assign hit = (i_req.cmd >= `CMD_TURN_ON_DELAY) && (i_req.cmd <= `CMD_START_TIME_FAULT_LIMIT);
    // Kept outside the register process so the converter forms no loop through it
    assign conv_in = loading_r ? i_nvm_words[idx_r] : linear_word_type'(i_req.data);

    // Register file: load, write check, read
    always_comb begin
        word_nxt = word_r;
        q_nxt = q_r;
        rd_nxt = rd_r;
        inv_nxt = inv_r;
        loading_nxt = loading_r;
        idx_nxt = idx_r;
        hq = conv_neg ? 12'h000 : 12'((13'(conv_q) + 13'h0001) >> 1);
        if (i_clear_faults) begin
            inv_nxt = 1'b0;
        end
        if (loading_r) begin
            // Reload one word per cycle; writes are held off meanwhile
            if (idx_r == 2'h0) begin
                if (hq > `HALF_MS_MAX) begin
                    hq = `HALF_MS_MAX;
                end
                word_nxt[0] = {`DELAY_EXP_RST, hq[10:0]}; // [R6]
                q_nxt[0] = {hq[10:0], 1'b0}; // [R6]
            end else begin
                word_nxt[idx_r] = conv_in;
                q_nxt[idx_r] = conv_neg ? 12'h000 :
                               (conv_q > max_q(idx_r)) ? max_q(idx_r) : conv_q;
            end
            idx_nxt = idx_r + 2'h1;
            loading_nxt = idx_r != 2'h2;
        end else if (i_req.wr && hit) begin
            if (wr_ok(sel, conv_q, conv_exact, conv_neg)) begin // [R5] [R10] [R15] [R19]
                word_nxt[sel] = conv_in;
                q_nxt[sel] = conv_q;
            end else begin
                inv_nxt = 1'b1; // [R4]
            end
        end
        if (i_restore) begin
            loading_nxt = 1'b1;
            idx_nxt = 2'h0;
        end
        if (i_req.rd) begin
            rd_nxt = hit ? word_r[sel] : 16'h0000;
        end
    end

    // Register file flip-flops; exponents reset to their fixed values
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            word_r[0] <= {`DELAY_EXP_RST, 11'h000}; // [R2]
            word_r[1] <= {`RAMP_EXP_RST, 11'h000}; // [R2]
            word_r[2] <= {`LIMIT_EXP_RST, 11'h000}; // [R2]
            for (int k = 0; k < 3; k++) begin
                q_r[k] <= 12'h000;
            end
            rd_r <= 16'h0000;
            inv_r <= 1'b0;
            loading_r <= 1'b1; // Mantissas load right after reset
            idx_r <= 2'h0;
        end else if (i_ce) begin
            word_r <= word_nxt;
            q_r <= q_nxt;
            rd_r <= rd_nxt;
            inv_r <= inv_nxt;
            loading_r <= loading_nxt;
            idx_r <= idx_nxt;
        end
    end

    seq_state_type st_r, st_nxt;
    logic [15:0] ref_r, ref_nxt, step_r, step_nxt, tel_r, tel_nxt;
    logic uv_r, uv_nxt, shut_r, shut_nxt, fault_r, fault_nxt;
    logic pend_r, pend_nxt, fin_r, fin_nxt, alert_r, alert_nxt;
    logic [MW-1:0] min_r, min_nxt; // Cycles since delay start
    logic start_ok, min_done, running;
    logic seq_start, seq_stop, seq_tick, seq_done, seq_busy;
    logic max_start, max_stop, max_done, max_busy;
    logic [11:0] seq_q, max_q_in, ramp_eff;
    logic [17:0] thr85, thr875;

    // Start source select
    always_comb begin
        unique case (i_start_source)
            2'h0: start_ok = 1'b1;
            2'h1: start_ok = i_operation_on;
            2'h2: start_ok = i_control_pin;
            2'h3: start_ok = i_operation_on && i_control_pin;
        endcase
    end

    // Short ramps stretched to the floor
    assign ramp_eff = (q_r[1] < `RAMP_MIN_Q) ? `RAMP_MIN_Q : q_r[1]; // [R11]
    assign min_done = min_r == MW'(MIN_START_CYCLES);
    assign running = (st_r == ST_RAMP) || (st_r == ST_ON);
    // Shift-and-add fractions of the target; close enough for these thresholds
    assign thr875 = 18'(i_target_voltage) - 18'(i_target_voltage >> 3);
    assign thr85 = thr875 - 18'(i_target_voltage >> 5) + 18'(i_target_voltage >> 7);

    quarter_timer #(.TICK_CYCLES(QUARTER_CYCLES)) seq_timer (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_start(seq_start),
        .i_stop(seq_stop),
        .i_quarters(seq_q),
        .o_tick(seq_tick),
        .o_done(seq_done),
        .o_busy(seq_busy)
    );

    quarter_timer #(.TICK_CYCLES(QUARTER_CYCLES)) max_timer (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_start(max_start),
        .i_stop(max_stop),
        .i_quarters(max_q_in),
        .o_tick(),
        .o_done(max_done),
        .o_busy(max_busy)
    );

    // Sequence: delay, ramp, regulate, fault handling
    always_comb begin
        st_nxt = st_r;
        ref_nxt = ref_r;
        step_nxt = step_r;
        uv_nxt = uv_r;
        shut_nxt = shut_r;
        fault_nxt = fault_r && !i_clear_faults;
        pend_nxt = pend_r;
        fin_nxt = fin_r || seq_done;
        min_nxt = min_done ? min_r : min_r + MW'(1);
        tel_nxt = i_telemetry_valid ? i_telemetry : tel_r; // [R14]
        seq_start = 1'b0;
        seq_stop = 1'b0;
        seq_q = q_r[0];
        max_start = 1'b0;
        max_stop = 1'b0;
        max_q_in = q_r[2];
        unique case (st_r)
            ST_IDLE: begin
                ref_nxt = 16'h0000;
                uv_nxt = 1'b0;
                shut_nxt = 1'b0;
                if (start_ok && !loading_r) begin
                    st_nxt = ST_DELAY; // [R1]
                    seq_start = 1'b1;
                    min_nxt = '0;
                    fin_nxt = 1'b0;
                end
            end
            ST_DELAY: begin
                if (!start_ok) begin
                    st_nxt = ST_IDLE;
                    seq_stop = 1'b1;
                end else if ((seq_done || fin_r) && min_done) begin // [R1] [R3]
                    st_nxt = ST_RAMP;
                    seq_start = 1'b1;
                    seq_q = ramp_eff; // [R7]
                    step_nxt = i_target_voltage >> clog(ramp_eff); // [R8] [R9]
                    max_start = q_r[2] != 12'h000; // [R12] [R16]
                end
            end
            ST_RAMP: begin
                if (seq_done) begin
                    ref_nxt = i_target_voltage; // [R7] [R9]
                    uv_nxt = 1'b1; // [R17]
                    st_nxt = ST_ON;
                end else if (seq_tick) begin
                    ref_nxt = (17'(ref_r) + 17'(step_r) > 17'(i_target_voltage)) ?
                              i_target_voltage : ref_r + step_r; // [R8]
                end
            end
            ST_ON: begin
                ref_nxt = i_target_voltage;
            end
            ST_OFF: begin
                ref_nxt = 16'h0000;
                uv_nxt = 1'b0;
                if (!start_ok) begin
                    st_nxt = ST_IDLE;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        if (running) begin
            if (max_busy && !pend_r && 18'(tel_r) >= thr85) begin
                max_stop = 1'b1; // [R12]
            end
            if (max_done && pend_r) begin
                // Delayed action: shut only if the fault persists
                pend_nxt = 1'b0;
                if (18'(tel_r) < thr875) begin
                    st_nxt = ST_OFF; // [R18]
                end
            end else if (max_done && 18'(tel_r) < thr875) begin
                fault_nxt = 1'b1; // [R13]
                if (i_fault_action == `ACT_DELAYED) begin
                    pend_nxt = 1'b1; // [R18]
                    max_start = 1'b1;
                    max_q_in = {7'h00, i_fault_delay_ms, 2'h0};
                end else if (i_fault_action == `ACT_IMMEDIATE) begin
                    st_nxt = ST_OFF; // [R18]
                end
            end
            if (!start_ok) begin
                st_nxt = ST_IDLE;
            end
            if (st_nxt != st_r && st_nxt != ST_ON) begin
                seq_stop = 1'b1;
                max_stop = !max_start;
                pend_nxt = 1'b0;
                shut_nxt = st_nxt == ST_OFF;
                uv_nxt = 1'b0; // [R17]
            end
        end
        alert_nxt = fault_nxt || inv_nxt; // [R4]
    end

    // Sequence flip-flops
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= ST_IDLE;
            ref_r <= 16'h0000;
            step_r <= 16'h0000;
            tel_r <= 16'h0000;
            uv_r <= 1'b0;
            shut_r <= 1'b0;
            fault_r <= 1'b0;
            pend_r <= 1'b0;
            fin_r <= 1'b0;
            alert_r <= 1'b0;
            min_r <= '0;
        end else if (i_ce) begin
            st_r <= st_nxt;
            ref_r <= ref_nxt;
            step_r <= step_nxt;
            tel_r <= tel_nxt;
            uv_r <= uv_nxt;
            shut_r <= shut_nxt;
            fault_r <= fault_nxt;
            pend_r <= pend_nxt;
            fin_r <= fin_nxt;
            alert_r <= alert_nxt;
            min_r <= min_nxt;
        end
    end

    assign o_rd_data = rd_r;
    assign o_ref_code = ref_r;
    assign o_uv_armed = uv_r;
    assign o_shutdown = shut_r;
    assign o_start_fault = fault_r;
    assign o_invalid_data = inv_r;
    assign o_alert = alert_r;

    sequence s_enter_ramp;
        i_ce && st_r == ST_DELAY && st_nxt == ST_RAMP;
    endsequence
    sequence s_expiry_low;
        i_ce && running && max_done && !pend_r && 18'(tel_r) < thr875;
    endsequence

    chk_bad_write_flag: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R4]
        i_ce && !loading_r && i_req.wr && hit && !wr_ok(sel, conv_q, conv_exact, conv_neg)
        |=> o_invalid_data && $stable(word_r[0]) && $stable(word_r[1]) && $stable(word_r[2]))
        else $error("invalid write not flagged");
    chk_min_delay: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R3]
        s_enter_ramp |-> min_r == MW'(MIN_START_CYCLES))
        else $error("ramp began before minimum delay");
    chk_ramp_floor: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R11]
        s_enter_ramp |-> seq_q >= `RAMP_MIN_Q)
        else $error("ramp shorter than floor");
    chk_limit_zero_off: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R16]
        s_enter_ramp and (q_r[2] == 12'h000) |=> !max_busy [*3])
        else $error("limit timer ran with zero limit");
    chk_fault_decide: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R13]
        s_expiry_low |=> o_start_fault && o_alert)
        else $error("start fault missed");
    chk_no_false_fault: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R13]
        i_ce && !fault_r && !(max_done && 18'(tel_r) < thr875) |=> !o_start_fault)
        else $error("start fault without low sample");
    chk_immediate_off: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R18]
        s_expiry_low and (i_fault_action == `ACT_IMMEDIATE && start_ok)
        |=> st_r == ST_OFF && o_shutdown)
        else $error("immediate action did not shut down");
    chk_uv_arm: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R17]
        i_ce && st_r == ST_RAMP && !o_uv_armed ##1 i_ce && o_uv_armed
        |-> $past(seq_done) && st_r == ST_ON)
        else $error("undervoltage armed outside ramp end");
    chk_start_delay: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R1]
        i_ce && st_r == ST_IDLE && start_ok && !loading_r
        |=> st_r == ST_DELAY && seq_busy == (q_r[0] != 12'h000))
        else $error("start condition did not begin delay");
endmodule
`default_nettype wire

// *** startup_timing_host_model.sv ***
// Management bus host model that issues one word request per call
`timescale 1ns/100ps
`default_nettype none
module startup_timing_host_model
    import startup_timing_pkg::*;
(
    input wire logic i_mclk,
    input wire logic [15:0] i_rd_data,
    output var cmd_req_type o_req
);
    // Idle bus until the bench calls a transfer
    initial o_req = '0;

    // One-cycle request; released fields show inverted values, never stale ones
    task automatic access(input logic wr, input logic [7:0] cmd, input logic [15:0] data,
                          output logic [15:0] rdat);
        @(posedge i_mclk);
        #1 o_req = '{wr: wr, rd: !wr, cmd: cmd, data: data};
        @(posedge i_mclk);
        #1 o_req = '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, data: ~data};
        // Read data is registered on the edge that takes the request and sampled one edge later
        @(posedge i_mclk);
        #1 rdat = i_rd_data;
    endtask
endmodule
`default_nettype wire

// *** startup_timing_sequencer_tb_top.sv ***
// Self-checking bench of the start-up sequencer
`timescale 1ns/100ps
`default_nettype none
module startup_timing_sequencer_tb_top;
    import startup_timing_pkg::*;
    logic mclk, resetn, clear_faults, telemetry_valid, operation_on;
    logic uv_armed, shutdown, start_fault, invalid_data, alert;
    logic [1:0] fault_action, start_src;
    logic [15:0] telemetry, rd_data, ref_code, rdat;
    cmd_req_type req;
    logic ce, restore; // Clock enable and reload strobe
    linear_word_type [2:0] nvm; // Stored words seen by the loader
    int n_fail = 0;
    int checks_done = 0;
    // Commanded output used by every start
    localparam logic [15:0] TARGET = 16'h1000;

    startup_timing_host_model i_startup_timing_host_model (
        .i_mclk(mclk), .i_rd_data(rd_data), .o_req(req));

    // Short quarter period keeps the run brief; expectations use 10 and 4
    startup_timing_sequencer #(.QUARTER_CYCLES(10), .MIN_START_CYCLES(4))
        i_startup_timing_sequencer (
        .i_mclk(mclk), .i_resetn(resetn), .i_ce(ce), .i_req(req),
        .i_nvm_words(nvm), .i_restore(restore),
        .i_clear_faults(clear_faults), .i_start_source(start_src),
        .i_operation_on(operation_on), .i_control_pin(1'b0),
        .i_target_voltage(TARGET), .i_telemetry(telemetry),
        .i_telemetry_valid(telemetry_valid), .i_fault_action(fault_action),
        .i_fault_delay_ms(3'h0), .o_rd_data(rd_data), .o_ref_code(ref_code),
        .o_uv_armed(uv_armed), .o_shutdown(shutdown), .o_start_fault(start_fault),
        .o_invalid_data(invalid_data), .o_alert(alert));

    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Counted comparison with hex report
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        i_startup_timing_host_model.access(1'b1, cmd, data, rdat);
    endtask

    task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
        i_startup_timing_host_model.access(1'b0, cmd, 16'h0000, rdat);
        check(rdat, exp);
    endtask

    // One-cycle pulses on the flag clear and telemetry strobe
    task automatic pulse_clear();
        @(posedge mclk);
        #1 clear_faults = 1'b1;
        @(posedge mclk);
        #1 clear_faults = 1'b0;
    endtask

    task automatic pulse_valid();
        @(posedge mclk);
        #1 telemetry_valid = 1'b1;
        @(posedge mclk);
        #1 telemetry_valid = 1'b0;
    endtask

    // Words after reset show reset exponents; unmapped code reads zero
    task automatic t_reset_words();
        rd_chk(8'h60, 16'hf800);
        rd_chk(8'h61, 16'hf000);
        rd_chk(8'h62, 16'hf800);
        rd_chk(8'h63, 16'h0000);
        $display("test reset_words done");
    endtask

    // Just past the top of each range is refused, the top itself is kept
    task automatic t_refuse();
        logic [7:0] cmds [3] = '{8'h60, 8'h61, 8'h62};
        logic [15:0] bad [3] = '{16'hf900, 16'hf080, 16'hf8ff};
        logic [15:0] keep [3] = '{16'hf800, 16'hf000, 16'hf800};
        logic [15:0] top [3] = '{16'hf8ff, 16'hf07f, 16'hf8fe};
        for (int k = 0; k < 3; k++) begin
            pulse_clear();
            wr(cmds[k], bad[k]);
            check({15'h0, invalid_data & alert}, 16'h0001);
            rd_chk(cmds[k], keep[k]);
            pulse_clear();
            wr(cmds[k], top[k]);
            check({15'h0, invalid_data | alert}, 16'h0000);
            rd_chk(cmds[k], top[k]);
        end
        $display("test refuse done");
    endtask

    // Reload while frozen is ignored; a real one rounds 0.375 ms to 0.5 ms
    task automatic t_restore();
        nvm[0] = 16'he803;
        ce = 1'b0;
        restore = 1'b1;
        @(posedge mclk);
        #1 ce = 1'b1;
        restore = 1'b0;
        rd_chk(8'h60, 16'hf8ff);
        @(posedge mclk);
        #1 restore = 1'b1;
        @(posedge mclk);
        #1 restore = 1'b0;
        repeat (4) @(posedge mclk);
        rd_chk(8'h60, 16'hf801);
        $display("test restore done");
    endtask

    // Start to regulation: delay, then a short ramp stretched to 0.5 ms
    task automatic t_ramp_up(input logic [15:0] dly, input int lo, input int hi);
        int n;
        wr(8'h60, dly);
        wr(8'h61, 16'hf001);
        wr(8'h62, 16'hf800);
        telemetry = 16'h0000;
        pulse_valid();
        operation_on = 1'b1;
        n = 0;
        // Bounded wait for the end of the ramp
        while (uv_armed !== 1'b1 && n < 400) begin
            @(posedge mclk);
            #1 n++;
        end
        check({15'h0, n >= lo && n <= hi}, 16'h0001);
        check(ref_code, TARGET);
        check({15'h0, start_fault}, 16'h0000);
        operation_on = 1'b0;
        repeat (3) @(posedge mclk);
        #1 check({15'h0, uv_armed}, 16'h0000);
        $display("test ramp_up done after %0d cycles", n);
    endtask

    // Limit runs out mid-ramp; low sample faults, good sample does not
    task automatic t_fault(input logic [1:0] act, input logic [15:0] tele,
                           input logic exp_fault, input logic exp_shut);
        fault_action = act;
        pulse_clear();
        wr(8'h60, 16'hf800);
        wr(8'h61, 16'hf008);
        wr(8'h62, 16'hf801);
        telemetry = tele;
        pulse_valid();
        operation_on = 1'b1;
        repeat (60) @(posedge mclk);
        #1 check({15'h0, start_fault}, {15'h0, exp_fault});
        check({15'h0, shutdown}, {15'h0, exp_shut});
        check({15'h0, uv_armed}, 16'h0000);
        operation_on = 1'b0;
        repeat (3) @(posedge mclk);
        #1 $display("test fault action %0d done", act);
    endtask

    // Verdict; the only place the run ends
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        resetn = 1'b0;
        clear_faults = 1'b0;
        telemetry_valid = 1'b0;
        operation_on = 1'b0;
        fault_action = 2'h0;
        start_src = 2'h1;
        telemetry = 16'h0000;
        ce = 1'b1;
        restore = 1'b0;
        nvm = 48'hf800_f000_f800;
        repeat (16) @(posedge mclk);
        #1 resetn = 1'b1;
        // Let the stored words load before the first request
        repeat (6) @(posedge mclk);
        t_reset_words();
        t_refuse();
        t_restore();
        t_ramp_up(16'hf800, 23, 30);
        t_ramp_up(16'hf802, 58, 68);
        t_fault(2'h0, 16'h0000, 1'b1, 1'b0);
        t_fault(2'h1, 16'h0000, 1'b1, 1'b1);
        t_fault(2'h2, 16'h0000, 1'b1, 1'b1);
        t_fault(2'h2, TARGET, 1'b0, 1'b0);
        tally_and_finish();
    end

    // Watchdog sized well past the few hundred cycles the tests need
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
